// ==== rtdseq_top.sv ====
// resistance temperature sequencer: APB registers, dummy and real discharge
// slots, mains-spaced repeat, fast oscillator gating and resonator calibration
// assumes an APB master on clk_in and a discharge comparator on discharge_sense_in
//
// Functional notes
// - repeat command runs the whole temperature measurement twice, mains-spaced.
// - dummy discharges on first port, then real ones on ports one to four.
// - interrupt flag rises once all real measurements of the run finish.
// - each port's value lands in its own result register zero to three.
// - dummy-count bit selects two or eight dummy measurements.
// - cycle-time bit selects 128 us or 512 us measurement cycle.
// - port-count bit selects two ports or four ports.
// - port-order bit reverses order; dummies then go to port four.
// - mains-base bit picks 50 Hz or 60 Hz for the repeat delay.
// - repeat-delay code picks 0.5, 0.75, 1 or 1.25 mains periods.
// - sense-invert bit inverts the discharge sense signal.
// - discharge shorter than eight reference periods stores zero.
// - no stop or timeout stores the all-ones error code.
// - oscillator setting above one gates the fast oscillator, with settling delay.
// - calibration times slow-clock periods, stores result, raises flag.
// - calibration length code gives 2, 4, 8 or 16 slow periods.
// - calibration result is 16.16 fixed point in divided fast periods.
// - the slow oscillator always runs; nothing can disable it. Reset here holds slow_osc_out low.
//
// Added by the designer: the register addresses and register access over APB.
`include "rtdseq_params.svh"
`default_nettype none

module rtdseq_top #(
	parameter int unsigned CYC_SHORT = `RTDSEQ_TCYC_SHORT_US * `RTDSEQ_CLK_MHZ,
	parameter int unsigned CYC_LONG  = `RTDSEQ_TCYC_LONG_US * `RTDSEQ_CLK_MHZ,
	parameter int unsigned QTR50_CYC = (`RTDSEQ_CLK_MHZ * 1000000) / (4 * `RTDSEQ_MAINS50_HZ),
	parameter int unsigned QTR60_CYC = (`RTDSEQ_CLK_MHZ * 1000000) / (4 * `RTDSEQ_MAINS60_HZ)
) (
	input  wire logic                        clk_in,
	input  wire logic                        rst_in,
	input  wire rtdseq_pkg::rtdseq_apb_req_t apb_in,
	output rtdseq_pkg::rtdseq_apb_rsp_t      apb_out,
	input  wire logic                        discharge_sense_in,
	input  wire logic                        slow_osc_in,
	output logic                             slow_osc_out,
	output logic [3:0]                       resistor_port_out,
	output logic                             fast_osc_en_out,
	output logic                             done_flag_out,
	output logic                             busy_out
);

	rtdseq_pkg::rtdseq_top_t s;
	rtdseq_pkg::rtdseq_top_t next_s;

	logic        t_done;
	logic        t_timeout;
	logic        t_running;
	logic [31:0] t_count;
	logic        slow_rise;
	logic        sense_stop;
	logic        setup_ph;
	logic        access_ph;
	logic        cmd_wr;
	logic [3:0]  n_dummy;
	logic [3:0]  n_total;
	logic [4:0]  cal_periods;
	logic [31:0] cycle_lim;
	logic [31:0] rdly_cyc;
	logic [47:0] cal_prod;
	logic        in_dummy;

	function automatic logic addr_ok(input logic [7:0] a);
		addr_ok = (a == `RTDSEQ_OFF_CFG0) || (a == `RTDSEQ_OFF_CFG6) ||
			(a == `RTDSEQ_OFF_SETTLE) || (a == `RTDSEQ_OFF_CMD) ||
			(a == `RTDSEQ_OFF_STATUS) || (a[7:4] == 4'h3 && a[1:0] == 2'b00);
	endfunction

	function automatic logic [3:0] port_onehot(input logic [1:0] p);
		port_onehot = 4'h1 << p;
	endfunction

	rtdseq_slow_edge rtdseq_slow_edge_inst (
		.clk_in        (clk_in),
		.rst_in        (rst_in),
		.slow_osc_in   (slow_osc_in),
		.slow_rise_out (slow_rise),
		.slow_osc_out  (slow_osc_out)
	);

	rtdseq_disch_timer rtdseq_disch_timer_inst (
		.clk_in      (clk_in),
		.rst_in      (rst_in),
		.start_in    (s.tstart),
		.stop_in     (sense_stop),
		.limit_in    (cycle_lim),
		.done_out    (t_done),
		.timeout_out (t_timeout),
		.running_out (t_running),
		.count_out   (t_count)
	);

	assign sense_stop = discharge_sense_in ^ s.cfg6[`RTDSEQ_B_INVERT];
	assign n_dummy = s.cfg0[`RTDSEQ_B_DUMMY] ? 4'(`RTDSEQ_DUMMY_MANY) : 4'(`RTDSEQ_DUMMY_FEW);
	assign n_total = n_dummy + (s.cfg0[`RTDSEQ_B_PORTS] ? 4'h4 : 4'h2);
	assign cycle_lim = s.cfg0[`RTDSEQ_B_CYCLE] ? 32'(CYC_LONG) : 32'(CYC_SHORT);
	assign rdly_cyc = 32'((s.cfg6[`RTDSEQ_B_MAINS] ? QTR60_CYC : QTR50_CYC) *
		(32'(s.cfg6[`RTDSEQ_B_RDLY +: 2]) + 32'h0000_0002));
	assign cal_periods = 5'h02 << s.cfg0[`RTDSEQ_B_CALLEN +: 2];
	// scale cycles of clk_in into nominal fast periods, 16 fraction bits
	assign cal_prod = (48'(s.wait_cnt) * 48'(`RTDSEQ_CAL_SCALE)) >> s.cfg0[`RTDSEQ_B_DIV +: 2];
	assign in_dummy = s.slot_cnt < n_dummy;
	assign setup_ph = apb_in.psel & ~apb_in.penable;
	assign access_ph = apb_in.psel & apb_in.penable;
	assign cmd_wr = access_ph & apb_in.pwrite & (apb_in.paddr == `RTDSEQ_OFF_CMD);

	always_comb
	begin
		logic [1:0] first_port;
		logic [1:0] next_port;
		logic [3:0] next_idx;
		first_port = s.cfg6[`RTDSEQ_B_ORDER] ? 2'h3 : 2'h0;
		next_idx = s.slot_cnt + 4'h1;
		next_port = first_port;
		if (next_idx >= n_dummy)
			next_port = s.cfg6[`RTDSEQ_B_ORDER] ? 2'(2'h3 - 2'(next_idx - n_dummy)) :
				2'(next_idx - n_dummy);
		next_s = s;
		next_s.tstart = 1'b0;
		next_s.osc_on = (s.cfg0[`RTDSEQ_B_OSC +: 2] == 2'h1) || (s.osc_on && s.state != rtdseq_pkg::ST_IDLE);

		if (setup_ph && !apb_in.pwrite)
		begin
			unique case (apb_in.paddr)
				`RTDSEQ_OFF_CFG0:   next_s.prdata = s.cfg0;
				`RTDSEQ_OFF_CFG6:   next_s.prdata = s.cfg6;
				`RTDSEQ_OFF_SETTLE: next_s.prdata = s.settle;
				`RTDSEQ_OFF_STATUS: next_s.prdata = {27'h0, s.state, (s.state != rtdseq_pkg::ST_IDLE), s.flag};
				`RTDSEQ_OFF_RES0:   next_s.prdata = s.res[0];
				`RTDSEQ_OFF_RES1:   next_s.prdata = s.res[1];
				`RTDSEQ_OFF_RES2:   next_s.prdata = s.res[2];
				`RTDSEQ_OFF_RES3:   next_s.prdata = s.res[3];
				default:            next_s.prdata = 32'h0000_0000;
			endcase
		end

		if (access_ph && apb_in.pwrite)
		begin
			if (apb_in.paddr == `RTDSEQ_OFF_CFG0)
				next_s.cfg0 = apb_in.pwdata;
			if (apb_in.paddr == `RTDSEQ_OFF_CFG6)
				next_s.cfg6 = apb_in.pwdata;
			if (apb_in.paddr == `RTDSEQ_OFF_SETTLE)
				next_s.settle = apb_in.pwdata;
		end

		// busy sequencer drops commands rather than queueing them
		if (cmd_wr && s.state == rtdseq_pkg::ST_IDLE && (apb_in.pwdata[7:0] == `RTDSEQ_OP_TEMP ||
			apb_in.pwdata[7:0] == `RTDSEQ_OP_TEMP_TWICE || apb_in.pwdata[7:0] == `RTDSEQ_OP_CAL))
		begin
			next_s.flag = 1'b0;
			next_s.twice = apb_in.pwdata[7:0] == `RTDSEQ_OP_TEMP_TWICE;
			next_s.is_cal = apb_in.pwdata[7:0] == `RTDSEQ_OP_CAL;
			next_s.second_run = 1'b0;
			next_s.slot_cnt = 4'h0;
			next_s.port = first_port;
			if (s.cfg0[`RTDSEQ_B_OSC +: 2] > 2'h1)
			begin
				next_s.osc_on = 1'b1;
				next_s.wait_cnt = s.settle;
				next_s.state = rtdseq_pkg::ST_SETTLE;
			end
			else if (apb_in.pwdata[7:0] == `RTDSEQ_OP_CAL)
				next_s.state = rtdseq_pkg::ST_CAL_ALIGN;
			else
			begin
				next_s.state = rtdseq_pkg::ST_SLOT;
				next_s.tstart = 1'b1;
				next_s.port_oh = port_onehot(first_port);
			end
		end
		else
		begin
			unique case (s.state)
				rtdseq_pkg::ST_IDLE:
					next_s.port_oh = 4'h0;
				rtdseq_pkg::ST_SETTLE:
				begin
					// measurement waits until the oscillator has settled
					if (s.wait_cnt == 32'h0000_0000)
					begin
						if (s.is_cal)
							next_s.state = rtdseq_pkg::ST_CAL_ALIGN;
						else
						begin
							next_s.state = rtdseq_pkg::ST_SLOT;
							next_s.tstart = 1'b1;
							next_s.port_oh = port_onehot(s.port);
						end
					end
					else
						next_s.wait_cnt = s.wait_cnt - 32'h0000_0001;
				end
				rtdseq_pkg::ST_SLOT:
				begin
					if (t_done)
					begin
						if (!in_dummy)
						begin
							if (t_timeout)
								next_s.res[s.port] = `RTDSEQ_ERR_OPEN;
							else if (t_count < 32'(`RTDSEQ_SHORT_CYC))
								next_s.res[s.port] = `RTDSEQ_ERR_SHORT;
							else
								next_s.res[s.port] = t_count;
						end
						if (next_idx == n_total)
						begin
							next_s.port_oh = 4'h0;
							next_s.slot_cnt = 4'h0;
							next_s.port = first_port;
							if (s.twice && !s.second_run)
							begin
								next_s.state = rtdseq_pkg::ST_REPEAT_WAIT;
								next_s.wait_cnt = rdly_cyc;
							end
							else
							begin
								next_s.flag = 1'b1;
								next_s.osc_on = s.cfg0[`RTDSEQ_B_OSC +: 2] == 2'h1;
								next_s.state = rtdseq_pkg::ST_IDLE;
							end
						end
						else
						begin
							next_s.slot_cnt = next_idx;
							next_s.port = next_port;
							next_s.port_oh = port_onehot(next_port);
							next_s.tstart = 1'b1;
						end
					end
				end
				rtdseq_pkg::ST_REPEAT_WAIT:
				begin
					if (s.wait_cnt == 32'h0000_0000)
					begin
						next_s.second_run = 1'b1;
						next_s.state = rtdseq_pkg::ST_SLOT;
						next_s.tstart = 1'b1;
						next_s.port_oh = port_onehot(s.port);
					end
					else
						next_s.wait_cnt = s.wait_cnt - 32'h0000_0001;
				end
				rtdseq_pkg::ST_CAL_ALIGN:
				begin
					// the interval starts on a slow edge so it spans whole periods
					if (slow_rise)
					begin
						next_s.state = rtdseq_pkg::ST_CAL_RUN;
						next_s.wait_cnt = 32'h0000_0000;
						next_s.cal_edges = 5'h00;
					end
				end
				rtdseq_pkg::ST_CAL_RUN:
				begin
					next_s.wait_cnt = s.wait_cnt + 32'h0000_0001;
					if (slow_rise)
					begin
						next_s.cal_edges = s.cal_edges + 5'h01;
						if (s.cal_edges + 5'h01 == cal_periods)
						begin
							next_s.res[0] = cal_prod[31:0];
							next_s.flag = 1'b1;
							next_s.osc_on = s.cfg0[`RTDSEQ_B_OSC +: 2] == 2'h1;
							next_s.state = rtdseq_pkg::ST_IDLE;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			s <= '0;
			s.state <= rtdseq_pkg::ST_IDLE;
			s.cfg0 <= `RTDSEQ_RST_CFG0;
			s.cfg6 <= `RTDSEQ_RST_CFG6;
			s.settle <= `RTDSEQ_RST_SETTLE;
		end
		else
			s <= next_s;
	end

	assign apb_out.prdata = s.prdata;
	assign apb_out.pready = 1'b1;
	assign apb_out.pslverr = access_ph & ~addr_ok(apb_in.paddr);
	assign resistor_port_out = s.port_oh;
	assign fast_osc_en_out = s.osc_on;
	assign done_flag_out = s.flag;
	assign busy_out = s.state != rtdseq_pkg::ST_IDLE;

	busy_cmd_ignored_a: assert property (@(posedge clk_in) disable iff (rst_in)
		(s.state != rtdseq_pkg::ST_IDLE && cmd_wr) |=> (s.twice == $past(s.twice) && s.is_cal == $past(s.is_cal)))
		else $error("start command changed a running sequence");

	dummy_port_first_a: assert property (@(posedge clk_in) disable iff (rst_in)
		(s.state == rtdseq_pkg::ST_SLOT && s.tstart && s.slot_cnt < n_dummy) |->
		s.port_oh == (s.cfg6[`RTDSEQ_B_ORDER] ? 4'h8 : 4'h1))
		else $error("dummy discharge on wrong port");

	short_gives_zero_a: assert property (@(posedge clk_in) disable iff (rst_in)
		(s.state == rtdseq_pkg::ST_SLOT && t_done && !t_timeout && !in_dummy &&
		t_count < 32'(`RTDSEQ_SHORT_CYC) && !cmd_wr) |=> s.res[$past(s.port)] == `RTDSEQ_ERR_SHORT)
		else $error("shorted port not stored as zero");

	open_gives_ones_a: assert property (@(posedge clk_in) disable iff (rst_in)
		(s.state == rtdseq_pkg::ST_SLOT && t_done && t_timeout && !in_dummy && !cmd_wr) |=>
		s.res[$past(s.port)] == `RTDSEQ_ERR_OPEN)
		else $error("open port not stored as error code");

	flag_at_end_a: assert property (@(posedge clk_in) disable iff (rst_in)
		$rose(s.flag) |-> ($past(s.state) == rtdseq_pkg::ST_CAL_RUN ||
		($past(s.state) == rtdseq_pkg::ST_SLOT && $past(s.slot_cnt) + 4'h1 == $past(n_total)
		&& (!$past(s.twice) || $past(s.second_run)))))
		else $error("flag raised before all measurements");

	repeat_delay_load_a: assert property (@(posedge clk_in) disable iff (rst_in)
		$rose(s.state == rtdseq_pkg::ST_REPEAT_WAIT) |-> (s.wait_cnt == $past(rdly_cyc) && s.twice))
		else $error("repeat delay loaded wrongly");

	settle_osc_on_a: assert property (@(posedge clk_in) disable iff (rst_in)
		(s.state == rtdseq_pkg::ST_SETTLE) |-> (s.osc_on && !t_running && s.port_oh == 4'h0))
		else $error("measurement began before oscillator settled");

	cal_length_end_a: assert property (@(posedge clk_in) disable iff (rst_in)
		(s.state == rtdseq_pkg::ST_CAL_RUN && slow_rise && s.cal_edges + 5'h01 == cal_periods && !cmd_wr) |=>
		(s.flag && s.state == rtdseq_pkg::ST_IDLE && s.res[0] == $past(cal_prod[31:0])))
		else $error("calibration did not end after selected periods");

	slow_always_runs_a: assert property (@(posedge clk_in) disable iff (rst_in)
		!$past(rst_in) |-> slow_osc_out == $past(slow_osc_in))
		else $error("slow clock not forwarded");

endmodule

`default_nettype wire

// ==== rtdseq_params.svh ====
// register offsets, field positions, reset values and timing figures of the
// resistance temperature sequencer; assumes a 250 MHz system clock
`ifndef RTDSEQ_PARAMS_SVH
`define RTDSEQ_PARAMS_SVH

`define RTDSEQ_OFF_CFG0      8'h00
`define RTDSEQ_OFF_CFG6      8'h18
`define RTDSEQ_OFF_SETTLE    8'h1C
`define RTDSEQ_OFF_CMD       8'h20
`define RTDSEQ_OFF_STATUS    8'h24
`define RTDSEQ_OFF_RES0      8'h30
`define RTDSEQ_OFF_RES1      8'h34
`define RTDSEQ_OFF_RES2      8'h38
`define RTDSEQ_OFF_RES3      8'h3C

`define RTDSEQ_B_DUMMY       15
`define RTDSEQ_B_CYCLE       16
`define RTDSEQ_B_PORTS       17
`define RTDSEQ_B_OSC         18
`define RTDSEQ_B_DIV         20
`define RTDSEQ_B_CALLEN      22
`define RTDSEQ_B_ORDER       11
`define RTDSEQ_B_MAINS       15
`define RTDSEQ_B_RDLY        18
`define RTDSEQ_B_INVERT      30

`define RTDSEQ_OP_TEMP       8'h01
`define RTDSEQ_OP_TEMP_TWICE 8'h02
`define RTDSEQ_OP_CAL        8'h03

`define RTDSEQ_RST_CFG0      32'h0000_0000
`define RTDSEQ_RST_CFG6      32'h0000_0000
`define RTDSEQ_RST_SETTLE    32'h0001_D4C0
`define RTDSEQ_ERR_OPEN      32'hFFFF_FFFF
`define RTDSEQ_ERR_SHORT     32'h0000_0000

`define RTDSEQ_CLK_MHZ       250
`define RTDSEQ_TCYC_SHORT_US 128
`define RTDSEQ_TCYC_LONG_US  512
`define RTDSEQ_SHORT_NS      2000
`define RTDSEQ_SHORT_CYC     ((`RTDSEQ_SHORT_NS * `RTDSEQ_CLK_MHZ + 999) / 1000)
`define RTDSEQ_MAINS50_HZ    50
`define RTDSEQ_MAINS60_HZ    60
`define RTDSEQ_DUMMY_FEW     2
`define RTDSEQ_DUMMY_MANY    8
`define RTDSEQ_CAL_SCALE     1049

`endif

// ==== rtdseq_pkg.sv ====
// types shared by the temperature sequencer and its two helper modules
// assumes rtdseq_params.svh for all numeric values
`default_nettype none

package rtdseq_pkg;

	typedef struct packed {
		logic [7:0]  paddr;
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [31:0] pwdata;
	} rtdseq_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} rtdseq_apb_rsp_t;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_SETTLE,
		ST_SLOT,
		ST_REPEAT_WAIT,
		ST_CAL_ALIGN,
		ST_CAL_RUN
	} rtdseq_state_t;

	typedef struct packed {
		logic        running;
		logic [31:0] count;
	} rtdseq_timer_t;

	typedef struct packed {
		logic prev;
		logic slow_copy;
	} rtdseq_edge_t;

	typedef struct packed {
		rtdseq_state_t     state;
		logic [31:0]       cfg0;
		logic [31:0]       cfg6;
		logic [31:0]       settle;
		logic [31:0]       prdata;
		logic [3:0][31:0]  res;
		logic [3:0]        slot_cnt;
		logic [3:0]        port_oh;
		logic [1:0]        port;
		logic              tstart;
		logic              twice;
		logic              second_run;
		logic              is_cal;
		logic              flag;
		logic              osc_on;
		logic [31:0]       wait_cnt;
		logic [4:0]        cal_edges;
	} rtdseq_top_t;

endpackage

`default_nettype wire

// ==== rtdseq_slow_edge.sv ====
// follows the always-running 32.768 kHz clock and flags its rising edges
// assumes slow_osc_in is already synchronous to clk_in
`default_nettype none

module rtdseq_slow_edge (
	input  wire logic clk_in,
	input  wire logic rst_in,
	input  wire logic slow_osc_in,
	output logic      slow_rise_out,
	output logic      slow_osc_out
);

	rtdseq_pkg::rtdseq_edge_t s;
	rtdseq_pkg::rtdseq_edge_t next_s;

	// no enable term: no control bit can switch the slow clock off, but reset holds its copy low
	always_comb
	begin
		next_s.prev = slow_osc_in;
		next_s.slow_copy = slow_osc_in;
	end

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			s <= '0;
		else
			s <= next_s;
	end

	assign slow_rise_out = slow_osc_in & ~s.prev;
	assign slow_osc_out = s.slow_copy;

endmodule

`default_nettype wire

// ==== rtdseq_disch_timer.sv ====
// times one capacitor discharge from a start pulse to the sense stop or a limit
// assumes stop_in is already polarity-corrected and synchronous
`default_nettype none

module rtdseq_disch_timer (
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	input  wire logic        start_in,
	input  wire logic        stop_in,
	input  wire logic [31:0] limit_in,
	output logic             done_out,
	output logic             timeout_out,
	output logic             running_out,
	output logic [31:0]      count_out
);

	rtdseq_pkg::rtdseq_timer_t s;
	rtdseq_pkg::rtdseq_timer_t next_s;

	always_comb
	begin
		next_s = s;
		done_out = 1'b0;
		timeout_out = 1'b0;
		if (start_in)
		begin
			next_s.running = 1'b1;
			next_s.count = 32'h0000_0000;
		end
		else if (s.running)
		begin
			if (stop_in)
			begin
				done_out = 1'b1;
				next_s.running = 1'b0;
			end
			else if (s.count + 32'h0000_0001 >= limit_in)
			begin
				// no stop inside the cycle time counts as an open sensor
				done_out = 1'b1;
				timeout_out = 1'b1;
				next_s.running = 1'b0;
			end
			else
				next_s.count = s.count + 32'h0000_0001;
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			s <= '0;
		else
			s <= next_s;
	end

	assign running_out = s.running;
	assign count_out = s.count;

endmodule

`default_nettype wire

// ==== rtdseq_disch_model.sv ====
// discharge comparator and slow clock source (period 2 * SLOW_HALF cycles of clk_in) facing the temperature sequencer
// assumes a one-hot port select from the sequencer, sampled on clk_in
`default_nettype none

module rtdseq_disch_model #(
	parameter int SLOW_HALF = 50
) (
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	input  wire logic [3:0]  port_in,
	input  wire logic        invert_in,
	input  wire logic [15:0] delay_in [4],
	output logic             sense_out,
	output logic             slow_clk_out,
	output logic [7:0]       stops_out [4]
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0]  port_q;
	logic [15:0] cnt;
	logic [15:0] slow_cnt = 16'h0000;
	logic        stop_now;
	logic        slow_q = 1'b0;
	int          idx;

	always_comb
	begin
		idx = 0;
		for (int i = 0; i < 4; i++)
			if (port_in[i])
				idx = i;
	end

	// one-cycle stop pulse, so a following slot on the same port is not cut short
	assign sense_out = stop_now ^ invert_in;

	always @(posedge clk_in)
	begin
		if (rst_in)
		begin
			port_q <= 4'h0;
			cnt <= 16'h0000;
			stop_now <= 1'b0;
			stops_out <= '{default: 8'h00};
		end
		else
		begin
			port_q <= port_in;
			cnt <= (port_in != port_q || stop_now) ? 16'h0000 : cnt + 16'h0001;
			// delay 16'hffff never fires: open sensor
			stop_now <= port_in != 4'h0 && port_in == port_q && !stop_now && cnt + 16'h0001 == delay_in[idx];
			if (stop_now)
				stops_out[idx] <= stops_out[idx] + 8'h01;
		end
	end

	// slow clock keeps running through reset as well
	always @(posedge clk_in)
	begin
		slow_cnt <= (slow_cnt == 16'(SLOW_HALF - 1)) ? 16'h0000 : slow_cnt + 16'h0001;
		if (slow_cnt == 16'(SLOW_HALF - 1))
			slow_q <= !slow_q;
	end

	assign slow_clk_out = slow_q;
endmodule

`default_nettype wire

// ==== tb_rtdseq_top.sv ====
// self-checking bench for the temperature sequencer over APB
// assumes rtdseq_disch_model stands for the sensor network and slow clock
`include "rtdseq_params.svh"
`default_nettype none

module tb_rtdseq_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int CS = 800;
	localparam int Q50 = 100;
	localparam int Q60 = 80;
	logic                        clk_in = 1'b0;
	logic                        rst_in = 1'b1;
	rtdseq_pkg::rtdseq_apb_req_t apb_in = '0;
	rtdseq_pkg::rtdseq_apb_rsp_t apb_out;
	logic                        sense, slow, slow_out, osc_en, flag, busy, inv = 1'b0, osc_q, err;
	logic [3:0]                  port;
	logic [15:0]                 dly [4] = '{16'h0258, 16'h0064, 16'hFFFF, 16'h02BC};
	logic [7:0]                  stops [4];
	logic [7:0]                  snap [4];
	logic [3:0]                  seq [$];
	logic [31:0]                 rd;
	int                          n_fail = 0, n_compared = 0, cyc = 0, gap = 0, max_gap, osc_t, port_t;

	rtdseq_top #(.CYC_SHORT(CS), .CYC_LONG(2 * CS), .QTR50_CYC(Q50), .QTR60_CYC(Q60)) rtdseq_top_inst (
		.clk_in(clk_in), .rst_in(rst_in), .apb_in(apb_in), .apb_out(apb_out), .discharge_sense_in(sense),
		.slow_osc_in(slow), .slow_osc_out(slow_out), .resistor_port_out(port), .fast_osc_en_out(osc_en),
		.done_flag_out(flag), .busy_out(busy));
	rtdseq_disch_model rtdseq_disch_model_inst (.clk_in(clk_in), .rst_in(rst_in), .port_in(port),
		.invert_in(inv), .delay_in(dly), .sense_out(sense), .slow_clk_out(slow), .stops_out(stops));

	initial
	begin
		forever #2 clk_in = ~clk_in;
	end

	always @(posedge clk_in)
	begin
		cyc <= cyc + 1;
		osc_q <= osc_en;
		if (osc_en === 1'b1 && osc_q !== 1'b1)
			osc_t <= cyc;
		if (port != 4'h0 && port_t == 0)
			port_t <= cyc;
		if (port != 4'h0 && (seq.size() == 0 || seq[$] != port))
			seq.push_back(port);
		gap <= (busy === 1'b1 && port == 4'h0) ? gap + 1 : 0;
		if (gap > max_gap)
			max_gap <= gap;
	end

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e)
		begin
			n_fail++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic near(input string nm, input int e, input logic [31:0] g, input int tol);
		n_compared++;
		if ($isunknown(g) || int'(g) > e + tol || int'(g) < e - tol)
		begin
			n_fail++;
			$display("BAD %s expected %0d seen %0d", nm, e, int'(g));
		end
	endtask

	// setup, access until pready, then release right after the pready edge
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd);
		@(posedge clk_in);
		apb_in <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: wd};
		@(posedge clk_in);
		apb_in.penable <= 1'b1;
		@(posedge clk_in);
		// only the watchdog ends a wait for pready
		while (apb_out.pready !== 1'b1)
			@(posedge clk_in);
		rd = apb_out.prdata;
		err = apb_out.pslverr;
		apb_in <= '0;
	endtask

	task automatic res(input int i);
		apb(`RTDSEQ_OFF_RES0 + 8'(4 * i), 1'b0, '0);
	endtask

	task automatic start(input logic [7:0] op);
		seq = {};
		max_gap = 0;
		port_t = 0;
		osc_t = 0;
		snap = stops;
		apb(`RTDSEQ_OFF_CMD, 1'b1, {24'h00_0000, op});
	endtask

	task automatic wait_done();
		@(posedge clk_in);
		for (int k = 0; k < 40000 && !(flag === 1'b1 && busy === 1'b0); k++)
			@(posedge clk_in);
		check("done_flag", 32'h0000_0001, {31'h0, flag});
	endtask

	task automatic run(input logic [7:0] op);
		start(op);
		wait_done();
	endtask

	function automatic logic [31:0] order();
		logic [31:0] v;
		v = '0;
		foreach (seq[i])
			v = {v[27:0], seq[i]};
		return v;
	endfunction

	initial
	begin
		#360000;
		n_fail++;
		final_report();
	end

	initial
	begin
		logic sq;
		int   miss;
		repeat (12) @(posedge clk_in);
		rst_in <= 1'b0;
		res(0);
		check("res_reset", '0, rd);
		apb(`RTDSEQ_OFF_SETTLE, 1'b0, '0);
		check("settle_reset", `RTDSEQ_RST_SETTLE, rd);
		apb(8'h40, 1'b0, '0);
		check("unmapped", 32'h8000_0000, {err, rd[30:0]});
		apb(`RTDSEQ_OFF_CFG0, 1'b1, 32'h0002_0000);
		start(`RTDSEQ_OP_TEMP);
		apb(`RTDSEQ_OFF_CMD, 1'b1, {24'h00_0000, `RTDSEQ_OP_CAL});
		wait_done();
		apb(`RTDSEQ_OFF_STATUS, 1'b0, '0);
		check("status_done", 32'h0000_0001, rd);
		check("order_fwd", 32'h0000_1248, order());
		check("dummies_two", 32'h0000_0003, 32'(stops[0] - snap[0]));
		res(0);
		near("res_a", 600, rd, 3);
		res(1);
		check("res_short", `RTDSEQ_ERR_SHORT, rd);
		res(2);
		check("res_open", `RTDSEQ_ERR_OPEN, rd);
		res(3);
		near("res_d", 700, rd, 3);
		dly <= '{16'h0258, 16'h028A, 16'h02BC, 16'h02EE};
		inv <= 1'b1;
		apb(`RTDSEQ_OFF_CFG6, 1'b1, 32'h4000_0800);
		apb(`RTDSEQ_OFF_CFG0, 1'b1, 32'h0002_8000);
		run(`RTDSEQ_OP_TEMP);
		check("order_rev", 32'h0000_8421, order());
		check("dummies_eight", 32'h0000_0009, 32'(stops[3] - snap[3]));
		for (int i = 0; i < 4; i++)
		begin
			res(i);
			near("res_rev", 600 + 50 * i, rd, 3);
		end
		inv <= 1'b0;
		dly <= '{16'h03E8, 16'h0226, 16'hFFFF, 16'hFFFF};
		apb(`RTDSEQ_OFF_CFG6, 1'b1, '0);
		for (int t = 0; t < 2; t++)
		begin
			apb(`RTDSEQ_OFF_CFG0, 1'b1, 32'(t) << 16);
			run(`RTDSEQ_OP_TEMP);
			res(0);
			near("res_cycle", t == 1 ? 1000 : -1, rd, 3);
			res(1);
			near("res_two_port", 550, rd, 3);
			res(2);
			near("res_kept", 700, rd, 3);
		end
		dly <= '{16'h0258, 16'h0226, 16'hFFFF, 16'hFFFF};
		apb(`RTDSEQ_OFF_CFG0, 1'b1, '0);
		for (int c = 0; c < 5; c++)
		begin
			apb(`RTDSEQ_OFF_CFG6, 1'b1, c == 4 ? 32'h0004_8000 : 32'(c) << 18);
			run(`RTDSEQ_OP_TEMP_TWICE);
			near("repeat_gap", (c == 4 ? Q60 * 3 : Q50 * (c + 2)) + 1, 32'(max_gap), 3);
			check("twice_runs", 32'h0000_0006, 32'(stops[0] - snap[0]));
		end
		apb(`RTDSEQ_OFF_CFG6, 1'b1, '0);
		apb(`RTDSEQ_OFF_SETTLE, 1'b1, 32'h0000_0032);
		apb(`RTDSEQ_OFF_CFG0, 1'b1, 32'h0008_0000);
		run(`RTDSEQ_OP_TEMP);
		near("settle_wait", 51, 32'(port_t - osc_t), 2);
		check("osc_off", '0, {31'h0, osc_en});
		for (int c = 0; c < 4; c++)
		begin
			apb(`RTDSEQ_OFF_CFG0, 1'b1, (32'(c) << 22) | (32'(c % 3) << 20));
			run(`RTDSEQ_OP_CAL);
			res(0);
			near("cal", ((2 << c) * 100 * 1049) >> (c % 3), rd, (3 * 1049) >> (c % 3));
		end
		apb(`RTDSEQ_OFF_CFG0, 1'b1, 32'h0004_0000);
		repeat (2) @(posedge clk_in);
		check("osc_always", 32'h0000_0001, {31'h0, osc_en});
		// every control bit set must still leave the slow clock forwarded
		apb(`RTDSEQ_OFF_CFG0, 1'b1, 32'hFFFF_FFFF);
		apb(`RTDSEQ_OFF_CFG6, 1'b1, 32'hFFFF_FFFF);
		miss = 0;
		sq = slow;
		repeat (200)
		begin
			@(posedge clk_in);
			miss += (slow_out !== sq);
			sq = slow;
		end
		check("slow_forward", '0, 32'(miss));
		final_report();
	end
endmodule

`default_nettype wire
